//--- src/ern_event_router.sv
// Top of the event routing network: channel multiplexers, pin filters, strobe and registers.
`timescale 1ns/1ps
`default_nettype none
module ern_event_router #(
  parameter int CHANNELS = ern_pkg::ERN_CHANNELS,
  parameter int PINS = ern_pkg::ERN_PINS
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire ern_pkg::ern_src_t SRC_EVENTS,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [CHANNELS-1:0] CHANNEL_EVENTS
);
  import ern_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [ERN_SRC_W-1:0] channel_source_select [CHANNELS];
  logic [ERN_SRC_W-1:0] next_sel [CHANNELS];
  logic [ERN_FILT_W-1:0] filt_cfg [CHANNELS];
  logic [ERN_FILT_W-1:0] next_filt [CHANNELS];
  logic [2*PINS-1:0] sense_cfg;
  logic [2*PINS-1:0] next_sense;
  logic [7:0] strobe;
  logic [7:0] next_strobe;
  logic [31:0] next_rdata;
  logic [CHANNELS-1:0] next_events;
  logic [CHANNELS-1:0] ch_last;
  logic [CHANNELS-1:0] next_last;

  logic [PINS-1:0] pin_event;
  logic [PINS-1:0] pin_level;
  logic [CHANNELS-1:0] filt_in;
  logic [CHANNELS-1:0] filt_out;
  logic [CHANNELS-1:0] raw_src;
  logic [CHANNELS-1:0] is_pin;

  logic [ERN_NUM_SRC-1:0] src_vec;

  // Timers, RTC, clock, converters and comparators form one flat source vector; pins are routed separately.
  assign src_vec = {{(ERN_NUM_SRC-22){1'b0}}, SRC_EVENTS.clk, SRC_EVENTS.cmp,
                    SRC_EVENTS.adc, SRC_EVENTS.rtc, SRC_EVENTS.timer};

  // ****************************************
  // Per pin sensing and per channel routing
  // ****************************************
  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++) begin : g_pin
      ern_pin_sense u_sense (
        .clk(MCLK),
        .rst_b(RST_B),
        .pin(PIN_IN[gp]),
        .mode(sense_cfg[2*gp +: 2]),
        .level(pin_level[gp]),
        .event_out(pin_event[gp])
      );
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_ch
      logic [ERN_SRC_W-1:0] idx;
      logic [ERN_SRC_W-1:0] pidx;
      // Every multiplexer sees the whole source vector and all pins.
      always_comb begin
        idx = channel_source_select[gc] - ERN_SRC_TMR_BASE;
        pidx = channel_source_select[gc] - ERN_SRC_PIN_BASE;
        is_pin[gc] = (channel_source_select[gc] >= ERN_SRC_PIN_BASE) &&
                     (pidx < ERN_SRC_W'(PINS));
        raw_src[gc] = 1'b0;
        filt_in[gc] = 1'b0;
        if (channel_source_select[gc] == ERN_SRC_OFF) begin
          raw_src[gc] = 1'b0;
        end else if (is_pin[gc]) begin
          filt_in[gc] = pin_event[pidx[$clog2(PINS)-1:0]];
        end else if (idx < ERN_SRC_W'(ERN_NUM_SRC)) begin
          raw_src[gc] = src_vec[idx[4:0]];
        end
      end

      ern_filter #(
        .CNT_W(ERN_FILT_W)
      ) u_filt (
        .clk(MCLK),
        .rst_b(RST_B),
        .samples_m1(filt_cfg[gc]),
        .in_event(filt_in[gc]),
        .out_event(filt_out[gc])
      );
    end
  endgenerate

  // ****************************************
  // Register bus and channel outputs
  // ****************************************
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_sel[i] = channel_source_select[i];
      next_filt[i] = filt_cfg[i];
    end
    next_sense = sense_cfg;
    next_strobe = ERN_STROBE_RST;
    next_rdata = 32'h00000000;
    if (WR) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (ADDR == ERN_OFS_SEL0 + 8'(4 * i)) begin
          next_sel[i] = WDATA[ERN_SRC_W-1:0];
        end
        if (ADDR == ERN_OFS_FILT0 + 8'(4 * i)) begin
          next_filt[i] = WDATA[ERN_FILT_W-1:0];
        end
      end
      if (ADDR == ERN_OFS_SENSE) begin
        next_sense = WDATA[2*PINS-1:0];
      end
      if (ADDR == ERN_OFS_STROBE) begin
        next_strobe = WDATA[7:0];
      end
    end
    if (RD) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (ADDR == ERN_OFS_SEL0 + 8'(4 * i)) begin
          next_rdata = {26'h0, channel_source_select[i]};
        end
        if (ADDR == ERN_OFS_FILT0 + 8'(4 * i)) begin
          next_rdata = {29'h0, filt_cfg[i]};
        end
      end
      if (ADDR == ERN_OFS_SENSE) begin
        next_rdata = {{(32-2*PINS){1'b0}}, sense_cfg};
      end
      if (ADDR == ERN_OFS_STROBE) begin
        next_rdata = {24'h0, strobe};
      end
      if (ADDR == ERN_OFS_STATUS) begin
        next_rdata = {{(32-CHANNELS){1'b0}}, ch_last};
      end
      if (ADDR == ERN_OFS_PINS) begin
        next_rdata = {{(32-PINS){1'b0}}, pin_level};
      end
    end
    // Strobe wins over the selected source for its one cycle; all consumers
    // share the same registered wire, so they act in the same cycle.
    // A filtered pin event still in the pipe is dropped once the channel no
    // longer selects a pin, so a channel turned off goes silent at once.
    next_events = (raw_src | (filt_out & is_pin)) & ~strobe[CHANNELS-1:0];
    next_events = next_events | strobe[CHANNELS-1:0];
    next_last = ch_last | next_events;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_source_select[i] <= ERN_SEL_RST;
        filt_cfg[i] <= ERN_FILT_RST;
      end
      sense_cfg <= ERN_SENSE_RST[2*PINS-1:0];
      strobe <= ERN_STROBE_RST;
      RDATA <= 32'h00000000;
      CHANNEL_EVENTS <= '0;
      ch_last <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_source_select[i] <= next_sel[i];
        filt_cfg[i] <= next_filt[i];
      end
      sense_cfg <= next_sense;
      strobe <= next_strobe;
      RDATA <= next_rdata;
      CHANNEL_EVENTS <= next_events;
      ch_last <= next_last;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_strobe_write;
    WR && ADDR == ERN_OFS_STROBE && WDATA[0];
  endsequence

  property p_strobe_pulse;
    @(posedge MCLK) disable iff (!RST_B)
    s_strobe_write ##1 !(WR && ADDR == ERN_OFS_STROBE) |=> CHANNEL_EVENTS[0] && strobe == 8'h00;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("Strobe did not fire channel 0.");

  property p_strobe_clear;
    @(posedge MCLK) disable iff (!RST_B)
    (strobe != 8'h00) && !(WR && ADDR == ERN_OFS_STROBE) |=> strobe == 8'h00;
  endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("Strobe did not clear.");

  property p_strobe_wins;
    @(posedge MCLK) disable iff (!RST_B)
    strobe[1] |=> CHANNEL_EVENTS[1];
  endproperty
  a_strobe_wins: assert property (p_strobe_wins) else $error("Strobe lost to source.");

  property p_off_silent;
    @(posedge MCLK) disable iff (!RST_B)
    channel_source_select[2] == ERN_SRC_OFF && !strobe[2] |=> !CHANNEL_EVENTS[2];
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("Off channel produced event.");

  property p_route_timer;
    @(posedge MCLK) disable iff (!RST_B)
    channel_source_select[3] == ERN_SRC_TMR_BASE && SRC_EVENTS.timer[0] |=> CHANNEL_EVENTS[3];
  endproperty
  a_route_timer: assert property (p_route_timer) else $error("Timer event not routed.");

  property p_route_other;
    @(posedge MCLK) disable iff (!RST_B)
    channel_source_select[4] == ERN_SRC_ADC_BASE && !SRC_EVENTS.adc[0] && !strobe[4]
      |=> !CHANNEL_EVENTS[4];
  endproperty
  a_route_other: assert property (p_route_other) else $error("Spurious channel event.");

  property p_filter_min;
    @(posedge MCLK) disable iff (!RST_B)
    filt_out[0] |-> $past(filt_in[0]) && is_pin[0];
  endproperty
  a_filter_min: assert property (p_filter_min) else $error("Filter passed too early.");

  property p_filter_one;
    @(posedge MCLK) disable iff (!RST_B)
    filt_cfg[5] == 3'h0 && filt_in[5] && !$past(filt_in[5]) |=> filt_out[5];
  endproperty
  a_filter_one: assert property (p_filter_one) else $error("One-sample filter did not pass.");

  property p_read_lat;
    @(posedge MCLK) disable iff (!RST_B)
    RD && ADDR == ERN_OFS_SEL0 |=> RDATA == {26'h0, $past(channel_source_select[0])};
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("Select readback wrong.");

endmodule
`default_nettype wire

//--- src/ern_pkg.sv
// Package of constants, types and register map for the event routing network.
package ern_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ERN_CHANNELS = 8;
  localparam int ERN_PINS = 8;
  localparam int ERN_SRC_W = 6;
  localparam int ERN_FILT_W = 3;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ERN_OFS_SEL0 = 8'h00;
  localparam logic [7:0] ERN_OFS_FILT0 = 8'h20;
  localparam logic [7:0] ERN_OFS_SENSE = 8'h40;
  localparam logic [7:0] ERN_OFS_STROBE = 8'h44;
  localparam logic [7:0] ERN_OFS_STATUS = 8'h48;
  localparam logic [7:0] ERN_OFS_PINS = 8'h4C;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [ERN_SRC_W-1:0] ERN_SEL_RST = 6'h00;
  localparam logic [ERN_FILT_W-1:0] ERN_FILT_RST = 3'h0;
  localparam logic [15:0] ERN_SENSE_RST = 16'h0000;
  localparam logic [7:0] ERN_STROBE_RST = 8'h00;

  // ****************************************
  // Source select encoding
  // ****************************************
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_OFF = 6'h00;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_TMR_BASE = 6'h01;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_RTC_BASE = 6'h09;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_ADC_BASE = 6'h0B;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_CMP_BASE = 6'h0F;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_CLK_BASE = 6'h13;
  localparam logic [ERN_SRC_W-1:0] ERN_SRC_PIN_BASE = 6'h17;
  localparam int ERN_NUM_SRC = 31;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ERN_SENSE_BOTH = 2'b00,
    ERN_SENSE_RISE = 2'b01,
    ERN_SENSE_FALL = 2'b10,
    ERN_SENSE_LEVEL = 2'b11
  } ern_sense_t;

  typedef struct packed {
    logic [7:0] timer;
    logic [1:0] rtc;
    logic [3:0] adc;
    logic [3:0] cmp;
    logic [3:0] clk;
  } ern_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ern_bus_t;

endpackage

//--- src/ern_pin_sense.sv
// Pin synchroniser and edge or level sense that turns one pin into event pulses.
`timescale 1ns/1ps
`default_nettype none
module ern_pin_sense (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic [1:0] mode,
  output logic level,
  output logic event_out
);
  import ern_pkg::*;

  logic [2:0] sync;
  logic stable;
  logic next_stable;
  logic next_event;

  // A change counts only once the second and third stages agree.
  always_comb begin
    next_stable = stable;
    if (sync[1] == sync[2]) begin
      next_stable = sync[1];
    end
    next_event = 1'b0;
    case (ern_sense_t'(mode))
      ERN_SENSE_RISE: next_event = next_stable & ~stable;
      ERN_SENSE_FALL: next_event = ~next_stable & stable;
      ERN_SENSE_BOTH: next_event = next_stable ^ stable;
      ERN_SENSE_LEVEL: next_event = next_stable;
      default: next_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync <= 3'h0;
      stable <= 1'b0;
      event_out <= 1'b0;
    end else begin
      sync <= {sync[1:0], pin};
      stable <= next_stable;
      event_out <= next_event;
    end
  end

  assign level = stable;

endmodule
`default_nettype wire

//--- src/ern_filter.sv
// Digital filter that passes a pin event after N consecutive samples.
`timescale 1ns/1ps
`default_nettype none
module ern_filter #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [CNT_W-1:0] samples_m1,
  input wire logic in_event,
  output logic out_event
);
  import ern_pkg::*;

  logic [CNT_W:0] run;
  logic [CNT_W:0] next_run;
  logic next_out;

  // The run counts consecutive cycles with the event present; the output
  // fires once, when the run first reaches the programmed sample count.
  // The extra top bit lets the run saturate beyond the largest count, so a
  // long run at the eight-sample setting still fires only once.
  always_comb begin
    next_run = run;
    next_out = 1'b0;
    if (!in_event) begin
      next_run = '0;
    end else begin
      if (run == {1'b0, samples_m1}) begin
        next_out = 1'b1;
      end
      if (!run[CNT_W]) begin
        next_run = run + (CNT_W+1)'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= '0;
      out_event <= 1'b0;
    end else begin
      run <= next_run;
      out_event <= next_out;
    end
  end

endmodule
`default_nettype wire

//--- verif/ern_periph_model.sv
// Peripheral model: requested source pulses, a free timer whose overflow is an event, a cascaded consumer.
`timescale 1ns/1ps
`default_nettype none
module ern_periph_model #(
  parameter int LO_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ern_pkg::ern_src_t trig,
  input wire logic run,
  input wire logic [2:0] use_ch,
  input wire logic [7:0] chan_ev,
  output var ern_pkg::ern_src_t src,
  output var logic [15:0] hi_cnt
);
  import ern_pkg::*;
  logic [LO_W-1:0] lo_cnt;
  // A short low timer keeps the cascade test brief; only the wrap matters to the router.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src <= '0;
      lo_cnt <= '0;
      hi_cnt <= 16'h0000;
    end else begin
      src <= trig;
      if (run) begin
        lo_cnt <= lo_cnt + 1'b1;
      end
      if (run && (&lo_cnt)) begin
        src.timer[0] <= 1'b1;
      end
      if (run && chan_ev[use_ch]) begin
        hi_cnt <= hi_cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/ern_event_router_bench.sv
// Self-checking bench for the event routing network.
`timescale 1ns/1ps
`default_nettype none
module ern_event_router_bench;
  import ern_pkg::*;
  localparam logic [1:0] PMODE [9] = '{ERN_SENSE_RISE, ERN_SENSE_FALL, ERN_SENSE_BOTH, ERN_SENSE_BOTH,
    ERN_SENSE_LEVEL, ERN_SENSE_LEVEL, ERN_SENSE_LEVEL, ERN_SENSE_LEVEL, ERN_SENSE_LEVEL};
  localparam int PFILT [9] = '{0, 0, 0, 2, 2, 2, 0, 7, 7};
  localparam int PLEN [9] = '{12, 12, 12, 12, 2, 12, 12, 7, 12};
  localparam int PEXP [9] = '{1, 1, 2, 0, 0, 1, 1, 0, 1};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  ern_src_t src_events;
  ern_src_t trig = '0;
  logic [7:0] pin_in = 8'h00;
  logic [7:0] channel_events;
  logic run = 1'b0;
  logic [15:0] hi_cnt;
  logic [31:0] ev_cnt = 32'h00000000;
  logic [31:0] c0;
  logic [31:0] d;
  logic [31:0] m;
  logic [2:0] wch = 3'h0;
  logic [2:0] ch;
  logic [2:0] p;
  int k;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'hE4A2;

  always #2 mclk = ~mclk;
  always @(posedge mclk) ev_cnt <= ev_cnt + 32'(channel_events[wch]);

  ern_event_router i_ern_event_router (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SRC_EVENTS(src_events), .PIN_IN(pin_in), .CHANNEL_EVENTS(channel_events));
  ern_periph_model i_ern_periph_model (.clk(mclk), .rst_b(rst_b), .trig(trig), .run(run), .use_ch(3'h0),
    .chan_ev(channel_events), .src(src_events), .hi_cnt(hi_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  function automatic logic [7:0] ch_a(input logic [7:0] base, input logic [2:0] c);
    return base + {3'h0, c, 2'h0};
  endfunction

  function automatic ern_src_t src_vec(input int code);
    ern_src_t v;
    v = '0;
    if (code < 9) v.timer[code-1] = 1'b1;
    else if (code < 11) v.rtc[code-9] = 1'b1;
    else if (code < 15) v.adc[code-11] = 1'b1;
    else if (code < 19) v.cmp[code-15] = 1'b1;
    else v.clk[code-19] = 1'b1;
    return v;
  endfunction

  // The channel answers one edge after the source pulse and for that one cycle only.
  task automatic fire(input ern_src_t v, input logic [7:0] exp);
    @(posedge mclk);
    trig <= v;
    @(posedge mclk);
    trig <= '0;
    @(posedge mclk);
    #1 check(32'(channel_events), 32'(exp));
    @(posedge mclk);
    #1 check(32'(channel_events), 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus_rd(ch_a(ERN_OFS_SEL0, 3'(i)), d);
      check(d, 32'(ERN_SEL_RST));
      bus_rd(ch_a(ERN_OFS_FILT0, 3'(i)), d);
      check(d, 32'(ERN_FILT_RST));
    end
    bus_rd(ERN_OFS_SENSE, d);
    check(d, 32'(ERN_SENSE_RST));
    bus_wr(8'h80, 32'hFFFFFFFF);
    bus_rd(8'h80, d);
    check(d, 32'h0);
    for (int s = 1; s < 23; s++) begin
      ch = 3'($random(seed));
      bus_wr(ch_a(ERN_OFS_SEL0, ch), 32'(s));
      bus_rd(ch_a(ERN_OFS_SEL0, ch), d);
      check(d, 32'(s));
      fire(src_vec(s) | ern_src_t'(18'($random(seed))), 8'h01 << ch);
      bus_wr(ch_a(ERN_OFS_SEL0, ch), 32'h0);
    end
    k = 1 + ({$random(seed)} % 22);
    for (int i = 0; i < 8; i++) bus_wr(ch_a(ERN_OFS_SEL0, 3'(i)), 32'(k));
    fire(src_vec(k), 8'hFF);
    bus_rd(ERN_OFS_STATUS, d);
    check(d, 32'hFF);
    for (int i = 0; i < 8; i++) bus_wr(ch_a(ERN_OFS_SEL0, 3'(i)), 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 32'hFF : 32'({$random(seed)} % 256);
      bus_wr(ERN_OFS_STROBE, m);
      @(posedge mclk);
      #1 check(32'(channel_events), m);
      @(posedge mclk);
      #1 check(32'(channel_events), 32'h0);
      bus_rd(ERN_OFS_STROBE, d);
      check(d, 32'h0);
    end
    p = 3'($random(seed));
    ch = 3'($random(seed));
    wch <= ch;
    bus_wr(ch_a(ERN_OFS_SEL0, ch), 32'(23 + p));
    for (int i = 0; i < 9; i++) begin
      bus_wr(ch_a(ERN_OFS_FILT0, ch), 32'(PFILT[i]));
      bus_wr(ERN_OFS_SENSE, 32'(PMODE[i]) << (2 * p));
      #1 c0 = ev_cnt;
      @(posedge mclk);
      pin_in[p] <= 1'b1;
      repeat (PLEN[i]) @(posedge mclk);
      pin_in[p] <= 1'b0;
      repeat (24) @(posedge mclk);
      #1 check(ev_cnt - c0, 32'(PEXP[i]));
    end
    @(posedge mclk);
    pin_in[p] <= 1'b1;
    repeat (6) @(posedge mclk);
    bus_rd(ERN_OFS_PINS, d);
    check(d, 32'(8'h01 << p));
    @(posedge mclk);
    pin_in[p] <= 1'b0;
    repeat (12) @(posedge mclk);
    bus_wr(ch_a(ERN_OFS_SEL0, 3'h0), 32'h1);
    @(posedge mclk);
    run <= 1'b1;
    repeat (84) @(posedge mclk);
    run <= 1'b0;
    #1 check(32'(hi_cnt), 32'h5);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    bus_rd(ch_a(ERN_OFS_SEL0, 3'h0), d);
    check(d, 32'h0);
    bus_rd(ERN_OFS_STATUS, d);
    check(d, 32'h0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
